/* File: logic/tmr_pkg.sv */
/*
 * constants, register map and state types of the 8-bit timer with shared scaler.
 * assumes an APB slave on pclk and a scaler that is shared with an outside watchdog.
 */
// Behaviour
// R1 - select bit clear: timer mode, one count per instruction cycle without scaler
// R2 - write to count blocks increments for the next two instruction cycles
// R3 - select bit set: counter mode, count on chosen edge of count pin
// R4 - edge select clear picks rising edge, set picks falling edge
// R5 - count pin is synchronised to phase clock before counting, adding delay
// R6 - one 8-bit scaler serves timer or watchdog, never both at once
// R7 - scaler count cannot be read or written through any register
// R8 - assignment clear: scaler feeds timer, ratios 1:2 to 1:256
// R9 - assignment set: scaler follows watchdog, ratios 1:1 to 1:128
// R10 - count write with timer assignment clears scaler, keeps assignment
// R11 - watchdog clear with watchdog assignment clears scaler count too
// R12 - software uses a safe sequence moving scaler from timer to watchdog
// R13 - wrap from ff to 00 sets overflow flag, bit 2 of interrupt control
// R14 - overflow request only while enable bit 5 of interrupt control is set
// R15 - software clears overflow flag before re-enabling; hardware never clears it
// R16 - timer stops in sleep, so overflow never wakes the processor
// R17 - ratio code n divides by 2^(n+1) for timer, 2^n for watchdog
// R18 - count steps per scaler pulse with timer assignment, else per source event
package tmr_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// printed offsets are indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_COUNT       = 8'h01;
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [7:0] IDX_OPTION_SETTINGS   = 8'h81;

	localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT       = {2'h0, IDX_TIMER_COUNT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CONTROL = {2'h0, IDX_INTERRUPT_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_OPTION_SETTINGS   = {2'h0, IDX_OPTION_SETTINGS, 2'h0};

	// option_settings fields
	localparam int unsigned OPT_CLOCK_SOURCE_BIT = 5;
	localparam int unsigned OPT_EDGE_BIT         = 4;
	localparam int unsigned OPT_ASSIGN_BIT       = 3;
	localparam int unsigned OPT_RATIO_LSB        = 0;
	localparam int unsigned RATIO_W              = 3;

	// interrupt_control fields
	localparam int unsigned INTC_FLAG_BIT   = 2;
	localparam int unsigned INTC_ENABLE_BIT = 5;

	localparam logic [REG_W-1:0] TIMER_COUNT_RST = 8'h00;
	localparam logic [REG_W-1:0] INTC_RST        = 8'h00;
	localparam logic [REG_W-1:0] OPTION_RST      = 8'hff;

	// one instruction cycle is four phase clocks
	localparam int unsigned        INSTR_DIV = 4;
	localparam int unsigned        PHASE_W   = 2;
	localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;

	// increments blocked after a count write, in instruction cycles
	localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

	localparam int unsigned SCALER_W = 8;

	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} tmr_sync_s;

	typedef struct packed {
		logic [SCALER_W-1:0] cnt;
	} tmr_scaler_s;

	typedef struct packed {
		logic [REG_W-1:0]   count;
		logic [REG_W-1:0]   intc;
		logic [REG_W-1:0]   option;
		logic [1:0]         inhibit;
		logic [PHASE_W-1:0] phase;
		logic               pready;
		logic               pslverr;
		logic [DATA_W-1:0]  prdata;
		logic               irq;
		logic               wdt_event;
	} tmr_state_s;

endpackage

/* File: logic/tmr_sync.sv */
/*
 * two-flop synchroniser for the count pin with rise and fall detection.
 * assumes the pin is asynchronous to pclk; edges are seen two to three clocks late.
 */
`timescale 1ns/1ns
module tmr_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);

	tmr_pkg::tmr_sync_s s_r;
	tmr_pkg::tmr_sync_s s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = pin; // R5
		s_nxt.stable = s_r.meta;
		s_nxt.prev   = s_r.stable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// edges judged only on the second and third flops
	assign rise = s_r.stable & ~s_r.prev;
	assign fall = ~s_r.stable & s_r.prev;

endmodule // tmr_sync

/* File: logic/tmr_scaler.sv */
/*
 * shared 8-bit scaler: power-of-two divider with selectable ratio and clear.
 * assumes in_tick and clear are single-cycle pulses on pclk.
 */
`timescale 1ns/1ns
module tmr_scaler (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         in_tick,
	input  wire logic                         clear,
	input  wire logic                         to_watchdog,
	input  wire logic [tmr_pkg::RATIO_W-1:0]  ratio,
	output logic                              out_tick
);

	tmr_pkg::tmr_scaler_s s_r;
	tmr_pkg::tmr_scaler_s s_nxt;
	logic [3:0]                    shift;
	logic [tmr_pkg::SCALER_W:0]    span;
	logic [tmr_pkg::SCALER_W-1:0]  mask;

	always_comb begin
		s_nxt = s_r;
		// timer side divides by 2^(n+1), watchdog side by 2^n
		if (to_watchdog) begin
			shift = {1'b0, ratio}; // R9 R17
		end else begin
			shift = {1'b0, ratio} + 4'h1; // R8 R17
		end
		span     = (9'h001 << shift) - 9'h001;
		mask     = span[tmr_pkg::SCALER_W-1:0];
		out_tick = in_tick & ((s_r.cnt & mask) == mask);
		// clear beats a coinciding tick: the tick belongs to the old interval
		if (clear) begin
			s_nxt.cnt = '0; // R10 R11
		end else if (in_tick) begin
			s_nxt.cnt = s_r.cnt + 8'h01; // R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // tmr_scaler

/* File: logic/tmr_timer.sv */
/*
 * 8-bit timer/counter with shared scaler behind an APB slave.
 * assumes pclk is the phase clock, the cpu drives sleep_mode, watchdog_tick
 * and watchdog_clear on pclk, and the count pin is asynchronous.
 */
`timescale 1ns/1ns
module tmr_timer (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [tmr_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [tmr_pkg::DATA_W-1:0]   pwdata,
	output logic      [tmr_pkg::DATA_W-1:0]   prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         count_input_pin,
	input  wire logic                         sleep_mode,
	input  wire logic                         watchdog_tick,
	input  wire logic                         watchdog_clear_instruction,
	output logic                              watchdog_event,
	output logic                              overflow_irq
);

	////////////////////////////////////////////////////////////////////////////
	// state and wires

	tmr_pkg::tmr_state_s s_r;
	tmr_pkg::tmr_state_s s_nxt;

	logic                          pin_rise;
	logic                          pin_fall;
	logic                          scaler_out;
	logic                          scaler_in;
	logic                          scaler_clear;
	logic                          clock_source_select;
	logic                          count_edge_select;
	logic                          scaler_assignment;
	logic [tmr_pkg::RATIO_W-1:0]   scaler_ratio;
	logic                          instr_tick;
	logic                          ext_edge;
	logic                          src_event;
	logic                          inc;
	logic                          overflow_set;
	logic                          access;
	logic                          done;
	logic                          hit_count;
	logic                          hit_intc;
	logic                          hit_option;
	logic                          mapped;
	logic                          wr_count;
	logic                          wr_intc;
	logic                          wr_option;

	////////////////////////////////////////////////////////////////////////////
	// submodules

	tmr_sync i_tmr_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (count_input_pin),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	tmr_scaler i_tmr_scaler (
		.pclk        (pclk),
		.presetn     (presetn),
		.in_tick     (scaler_in),
		.clear       (scaler_clear),
		.to_watchdog (scaler_assignment),
		.ratio       (scaler_ratio),
		.out_tick    (scaler_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// option fields and apb decode

	assign clock_source_select = s_r.option[tmr_pkg::OPT_CLOCK_SOURCE_BIT];
	assign count_edge_select   = s_r.option[tmr_pkg::OPT_EDGE_BIT];
	assign scaler_assignment   = s_r.option[tmr_pkg::OPT_ASSIGN_BIT];
	assign scaler_ratio        = s_r.option[tmr_pkg::OPT_RATIO_LSB +: tmr_pkg::RATIO_W];

	assign hit_count  = (paddr == tmr_pkg::ADDR_TIMER_COUNT);
	assign hit_intc   = (paddr == tmr_pkg::ADDR_INTERRUPT_CONTROL);
	assign hit_option = (paddr == tmr_pkg::ADDR_OPTION_SETTINGS);
	assign mapped     = hit_count | hit_intc | hit_option;

	// one wait state: pready rises in the second access cycle
	assign access    = psel & penable;
	assign done      = access & s_r.pready;
	assign wr_count  = done & pwrite & hit_count;
	assign wr_intc   = done & pwrite & hit_intc;
	assign wr_option = done & pwrite & hit_option;

	////////////////////////////////////////////////////////////////////////////
	// count sources

	assign instr_tick = (s_r.phase == tmr_pkg::PHASE_LAST);

	// counting edge from the synchronised pin only
	assign ext_edge = count_edge_select ? pin_fall : pin_rise; // R4 R5

	// the whole count path halts in sleep, so no overflow can arise there
	assign src_event = ~sleep_mode
		& (clock_source_select ? ext_edge : instr_tick); // R1 R3 R16

	// scaler belongs to exactly one user at a time
	assign scaler_in = scaler_assignment ? watchdog_tick : src_event; // R6

	// no register path reaches the scaler count; only these clears touch it
	assign scaler_clear = (wr_count & ~scaler_assignment)
		| (watchdog_clear_instruction & scaler_assignment); // R7 R10 R11

	assign inc = (s_r.inhibit == 2'h0)
		& (scaler_assignment ? src_event : scaler_out); // R2 R18

	assign overflow_set = inc & ~wr_count & (s_r.count == 8'hff); // R13

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;

		s_nxt.phase = s_r.phase + 2'h1;

		// apb answer, registered for one cycle
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;
		if (access & ~s_r.pready) begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = ~mapped;
			s_nxt.prdata  = '0;
			if (hit_count) begin
				s_nxt.prdata = {24'h000000, s_r.count};
			end else if (hit_intc) begin
				s_nxt.prdata = {24'h000000, s_r.intc};
			end else if (hit_option) begin
				s_nxt.prdata = {24'h000000, s_r.option};
			end
		end

		// inhibit counts down in instruction cycles
		if ((s_r.inhibit != 2'h0) & instr_tick) begin
			s_nxt.inhibit = s_r.inhibit - 2'h1;
		end

		// a write wins over a coinciding increment
		if (wr_count) begin
			s_nxt.count   = pwdata[tmr_pkg::REG_W-1:0];
			s_nxt.inhibit = tmr_pkg::INHIBIT_CYCLES; // R2
		end else if (inc) begin
			s_nxt.count = s_r.count + 8'h01; // R1 R3 R18
		end

		// assignment changes take effect at once; safe switching is up to software
		if (wr_option) begin
			s_nxt.option = pwdata[tmr_pkg::REG_W-1:0];
		end

		// flag only ever cleared by software; a same-cycle overflow still sets it
		if (wr_intc) begin
			s_nxt.intc = pwdata[tmr_pkg::REG_W-1:0];
		end
		if (overflow_set) begin
			s_nxt.intc[tmr_pkg::INTC_FLAG_BIT] = 1'b1; // R13
		end

		s_nxt.irq = s_nxt.intc[tmr_pkg::INTC_FLAG_BIT]
			& s_nxt.intc[tmr_pkg::INTC_ENABLE_BIT]; // R14

		// unassigned watchdog sees its raw tick, assigned one the scaled tick
		s_nxt.wdt_event = scaler_assignment ? scaler_out : watchdog_tick; // R9
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r           <= '0;
			s_r.count     <= tmr_pkg::TIMER_COUNT_RST;
			s_r.intc      <= tmr_pkg::INTC_RST;
			s_r.option    <= tmr_pkg::OPTION_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata         = s_r.prdata;
	assign pready         = s_r.pready;
	assign pslverr        = s_r.pslverr;
	assign overflow_irq   = s_r.irq;
	assign watchdog_event = s_r.wdt_event;

endmodule // tmr_timer

/* File: test/tmr_properties.sv */
/* port assertions of the timer with shared scaler.
 * assumes it is bound into every tmr_timer instance. */
`timescale 1ns/1ns
module tmr_properties (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
	input wire logic [tmr_pkg::DATA_W-1:0] pwdata,
	input wire logic [tmr_pkg::DATA_W-1:0] prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       sleep_mode,
	input wire logic                       watchdog_tick,
	input wire logic                       watchdog_event,
	input wire logic                       overflow_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic wr_int;
	logic mapped;
	assign acc = psel && penable && pready;
	assign wr_int = acc && pwrite && paddr == tmr_pkg::ADDR_INTERRUPT_CONTROL;
	assign mapped = paddr == tmr_pkg::ADDR_TIMER_COUNT
		|| paddr == tmr_pkg::ADDR_INTERRUPT_CONTROL || paddr == tmr_pkg::ADDR_OPTION_SETTINGS;
	////////////////////////////////////////
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no ready after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_irq_masked: assert property (wr_int && !pwdata[5] |=> !overflow_irq)
		else $error("request while masked");
	a_irq_raised: assert property (wr_int && pwdata[5] && pwdata[2] |=> overflow_irq)
		else $error("no request with flag and enable");
	a_wdt_source: assert property (watchdog_event |-> $past(watchdog_tick))
		else $error("watchdog event without tick");
	// a register write may still raise it, counting may not
	a_sleep_quiet: assert property (sleep_mode && !(acc && pwrite) |=> !$rose(overflow_irq))
		else $error("overflow during sleep");
endmodule // tmr_properties

bind tmr_timer tmr_properties i_tmr_properties (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_mode, .watchdog_tick,
	.watchdog_event, .overflow_irq);

/* File: test/tmr_pulse_src.sv */
/* external pulse source on the count pin.
 * assumes pclk paces it; the pin is a driven level, idle at its last value. */
`timescale 1ns/1ns
module tmr_pulse_src (
	input wire logic pclk,
	output logic     pin
);
	initial pin = 1'b0;
	// wide spacing keeps each level well past the synchroniser and the write inhibit
	task automatic toggle(input int n);
		repeat (n) begin
			repeat (12) @(posedge pclk);
			pin <= ~pin;
		end
	endtask
endmodule // tmr_pulse_src

/* File: test/test_eight_bit_timer_with_shared_prescaler.sv */
/* self-checking bench of the timer with shared scaler.
 * assumes one apb wait state and tmr_pulse_src on the count pin. */
`timescale 1ns/1ns
module test_eight_bit_timer_with_shared_prescaler;
	logic                       pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [tmr_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0]                pwdata = '0, prdata, rd;
	logic                       pready, pslverr, err, watchdog_event, overflow_irq;
	logic                       count_input_pin, sleep_mode = 0, watchdog_tick = 0;
	logic                       watchdog_clear_instruction = 0;
	int                         failures = 0, samples_checked = 0, wev_n = 0;
	// count, interrupt control, option
	logic [tmr_pkg::ADDR_W-1:0] ad[3] = '{tmr_pkg::ADDR_TIMER_COUNT,
		tmr_pkg::ADDR_INTERRUPT_CONTROL, tmr_pkg::ADDR_OPTION_SETTINGS};
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) if (watchdog_event === 1'b1) wev_n <= wev_n + 1;
	tmr_timer i_tmr_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .count_input_pin, .sleep_mode, .watchdog_tick,
		.watchdog_clear_instruction, .watchdog_event, .overflow_irq);
	tmr_pulse_src i_tmr_pulse_src (.pclk, .pin(count_input_pin));
	////////////////////////////////////////
	task end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, s);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task rng(input string n, input logic [7:0] lo, hi, s);
		samples_checked++;
		if ((s >= lo && s <= hi) !== 1'b1) begin
			failures++;
			$display("[FAIL] %s exp %h..%h got %h", n, lo, hi, s);
		end
	endtask
	task apb(input logic w, input logic [tmr_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			failures++;
			end_sim;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input string n, input int r, input logic [7:0] e);
		apb(1'b0, ad[r], 8'h00);
		chk(n, {24'h0, e}, rd);
	endtask
	////////////////////////////////////////
	task t_reset;
		rchk("count", 0, 8'h00);
		rchk("intc", 1, 8'h00);
		rchk("option", 2, 8'hff);
		apb(1'b0, 12'h008, 8'h00);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
	endtask
	task t_timer;
		apb(1'b1, ad[2], 8'h08);
		apb(1'b1, ad[0], 8'h10);
		repeat (40) @(posedge pclk);
		apb(1'b0, ad[0], 8'h00);
		rng("timer", 8'h17, 8'h19, rd[7:0]);
	endtask
	task t_scaler;
		logic [7:0] e;
		for (int n = 0; n < 4; n++) begin
			apb(1'b1, ad[2], 8'(n));
			apb(1'b1, ad[0], 8'h00);
			repeat (160) @(posedge pclk);
			apb(1'b0, ad[0], 8'h00);
			e = 8'(39 >> (n + 1));
			rng("scaled", e - 8'h1, e + 8'h1, rd[7:0]);
		end
	endtask
	task t_ovf;
		// clear count and scaler before handing the scaler to the watchdog
		apb(1'b1, ad[0], 8'h00);
		apb(1'b1, ad[2], 8'h08);
		apb(1'b1, ad[1], 8'h20);
		apb(1'b1, ad[0], 8'hfd);
		repeat (40) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, overflow_irq});
		rchk("flag", 1, 8'h24);
		apb(1'b1, ad[1], 8'h04);
		@(posedge pclk);
		chk("masked", 32'h0, {31'h0, overflow_irq});
		apb(1'b1, ad[1], 8'h00);
		apb(1'b1, ad[1], 8'h20);
		@(posedge pclk);
		chk("cleared", 32'h0, {31'h0, overflow_irq});
	endtask
	task t_sleep;
		sleep_mode <= 1'b1;
		apb(1'b1, ad[0], 8'h50);
		repeat (40) @(posedge pclk);
		rchk("sleep", 0, 8'h50);
		sleep_mode <= 1'b0;
	endtask
	// three toggles from low give two rises, one from high gives one fall
	task t_cnt;
		apb(1'b1, ad[2], 8'h28);
		apb(1'b1, ad[0], 8'h00);
		i_tmr_pulse_src.toggle(3);
		repeat (8) @(posedge pclk);
		rchk("rise", 0, 8'h02);
		apb(1'b1, ad[2], 8'h38);
		apb(1'b1, ad[0], 8'h00);
		i_tmr_pulse_src.toggle(1);
		repeat (8) @(posedge pclk);
		rchk("fall", 0, 8'h01);
	endtask
	task t_wdt(input logic [7:0] opt, input int nt, input logic [31:0] e);
		int base;
		apb(1'b1, ad[2], opt);
		// with opt 8'h0a two ticks leave the scaler mid-interval, so the clear below matters
		repeat (2) begin
			@(posedge pclk);
			watchdog_tick <= 1'b1;
			@(posedge pclk);
			watchdog_tick <= 1'b0;
		end
		@(posedge pclk);
		watchdog_clear_instruction <= 1'b1;
		@(posedge pclk);
		watchdog_clear_instruction <= 1'b0;
		base = wev_n;
		repeat (nt) begin
			@(posedge pclk);
			watchdog_tick <= 1'b1;
			@(posedge pclk);
			watchdog_tick <= 1'b0;
			@(posedge pclk);
		end
		repeat (3) @(posedge pclk);
		chk("wdt events", e, 32'(wev_n - base));
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_timer;
		t_scaler;
		t_ovf;
		t_sleep;
		t_cnt;
		t_wdt(8'h0a, 7, 32'h1);
		t_wdt(8'h08, 3, 32'h3);
		t_wdt(8'h00, 3, 32'h3);
		end_sim;
	end
endmodule // test_eight_bit_timer_with_shared_prescaler
